/* File: rtl/odrd_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef ODRD_REGS_SVH
`define ODRD_REGS_SVH

// ==========================================================
// Register map (byte addresses)
`define ODRD_CTRL_OFFS 8'h00
`define ODRD_STAT_OFFS 8'h04
`define ODRD_PEND_OFFS 8'h08

// ==========================================================
// Control register fields
`define ODRD_CTRL_W 16
`define ODRD_COARSE_HI 15
`define ODRD_COARSE_LO 13
`define ODRD_FINE_HI 10
`define ODRD_FINE_LO 0
`define ODRD_CTRL_RST 16'h0000

// ==========================================================
// Divider arithmetic
`define ODRD_DIV_W 17
`define ODRD_BASE_MULT 17'h00180
`define ODRD_FINE_SAT 11'h5ff
`define ODRD_DIV_RST 17'h00600

// ==========================================================
// Rate change hold-off, in output data periods
`define ODRD_HOLD_PERIODS 5'h10

`endif

/* File: rtl/odrd_pkg.sv */
// Types shared by the output data rate divider
package odrd_pkg;

    // APB request from the bus master
    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } odrd_apb_req_t;

    // APB answer to the bus master
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } odrd_apb_rsp_t;

    // Hold-off sequencer states
    typedef enum logic [0:0] {
        ODRD_RUN,
        ODRD_HOLD
    } odrd_state_t;

endpackage

/* File: rtl/odrd_top.sv */
// Output data rate divider: period register, divider arithmetic and sample timer
`timescale 1ns/1ps
`default_nettype none
`include "odrd_regs.svh"

// What this block does
// RL1 - Fine value times fine factor lengthens period
// RL2 - Fine factors 1,32,16,8,4,2,1,1 per code
// RL3 - Fine values above 1535 act as 1535
// RL4 - Fine zero gives 49152, 24576, 12288 cycles
// RL5 - Reserved bits written zero, ignored by arithmetic
// RL6 - Divider is coarse times 384 plus fine
// RL7 - Coarse factors 4,128,64,32,16 from bits 15:13
// RL8 - New rate applies after 16 old periods
// RL9 - Rate register moves as 16 bits
module odrd_top
    import odrd_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire odrd_apb_req_t apb_req_i,
    output var odrd_apb_rsp_t apb_rsp_o,
    output logic sample_tick_o,
    output logic [`ODRD_DIV_W-1:0] active_div_o
);

    // ==========================================================
    // Divider arithmetic

    // Coarse cycle factor of a coarse select code
    function automatic logic [7:0] coarse_factor(input logic [2:0] code);
        logic [7:0] f;
        f = 8'h01;
        case (code)
            3'h0: f = 8'h04; // RL7
            3'h1: f = 8'h80; // RL7
            3'h2: f = 8'h40; // RL7
            3'h3: f = 8'h20; // RL7
            3'h4: f = 8'h10; // RL7
            3'h5: f = 8'h08;
            3'h6: f = 8'h02;
            default: f = 8'h01;
        endcase
        return f;
    endfunction

    // Fine cycle factor of a coarse select code
    function automatic logic [5:0] fine_factor(input logic [2:0] code);
        logic [5:0] f;
        f = 6'h01;
        case (code)
            3'h1: f = 6'h20; // RL2
            3'h2: f = 6'h10; // RL2
            3'h3: f = 6'h08; // RL2
            3'h4: f = 6'h04; // RL2
            3'h5: f = 6'h02; // RL2
            default: f = 6'h01; // RL2
        endcase
        return f;
    endfunction

    // Period in clock cycles for a control word; reserved bits never read
    function automatic logic [`ODRD_DIV_W-1:0] period_of(input logic [`ODRD_CTRL_W-1:0] ctrl);
        logic [2:0] code;
        logic [10:0] fine;
        logic [`ODRD_DIV_W-1:0] base;
        logic [`ODRD_DIV_W-1:0] extra;
        code = ctrl[`ODRD_COARSE_HI:`ODRD_COARSE_LO]; // RL7 RL5
        fine = ctrl[`ODRD_FINE_HI:`ODRD_FINE_LO]; // RL5
        if (fine > `ODRD_FINE_SAT) begin
            fine = `ODRD_FINE_SAT; // RL3
        end
        base = `ODRD_DIV_W'(coarse_factor(code)) * `ODRD_BASE_MULT; // RL6 RL4
        extra = `ODRD_DIV_W'(fine_factor(code)) * `ODRD_DIV_W'(fine); // RL1
        return base + extra; // RL6
    endfunction

    // ==========================================================
    // State

    logic [`ODRD_CTRL_W-1:0] ctrl_q;
    logic [`ODRD_DIV_W-1:0] pend_div_q;
    logic [`ODRD_DIV_W-1:0] active_div_q;
    logic [`ODRD_DIV_W-1:0] cnt_q;
    logic [4:0] hold_q;
    odrd_state_t state_q;
    logic tick_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic acc_req;
    logic wr_fire;
    logic rd_hit;
    logic period_end;

    // ==========================================================
    // APB slave

    // Access phase waiting for the one wait state to elapse
    assign acc_req = apb_req_i.psel & apb_req_i.penable & ~pready_q;
    // Write completes at the edge where pready is sampled high
    assign wr_fire = apb_req_i.psel & apb_req_i.penable & pready_q & apb_req_i.pwrite;
    assign period_end = (cnt_q == active_div_q - `ODRD_DIV_W'(1));

    // Address decode for read data and error
    always_comb begin
        rd_hit = 1'b1;
        if (apb_req_i.paddr == `ODRD_CTRL_OFFS) begin
            rd_hit = 1'b1;
        end else if (apb_req_i.paddr == `ODRD_STAT_OFFS) begin
            rd_hit = ~apb_req_i.pwrite;
        end else if (apb_req_i.paddr == `ODRD_PEND_OFFS) begin
            rd_hit = ~apb_req_i.pwrite;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Ready pulse, one wait state after the access phase begins
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= acc_req;
            pslverr_q <= acc_req & ~rd_hit;
        end
    end

    // Read data captured with the ready pulse; 16-bit control in low half
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prdata_q <= 32'h0000_0000;
        end else if (acc_req & ~apb_req_i.pwrite) begin
            if (apb_req_i.paddr == `ODRD_CTRL_OFFS) begin
                prdata_q <= {16'h0000, ctrl_q}; // RL9
            end else if (apb_req_i.paddr == `ODRD_STAT_OFFS) begin
                prdata_q <= {15'h0000, active_div_q};
            end else if (apb_req_i.paddr == `ODRD_PEND_OFFS) begin
                // Pending flag in bit 31, periods left in 21:17, divider in 16:0
                prdata_q <= {state_q == ODRD_HOLD, 9'h000, hold_q, pend_div_q};
            end else begin
                prdata_q <= 32'h0000_0000;
            end
        end else if (acc_req) begin
            prdata_q <= 32'h0000_0000;
        end
    end

    // Control register: the whole 16-bit word is taken at once
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_q <= `ODRD_CTRL_RST;
        end else if (wr_fire && apb_req_i.paddr == `ODRD_CTRL_OFFS) begin
            ctrl_q <= apb_req_i.pwdata[`ODRD_CTRL_W-1:0]; // RL9
        end
    end

    // ==========================================================
    // Rate change sequencer

    // A write arms a 16-period hold-off; a rewrite restarts it
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= ODRD_RUN;
            hold_q <= 5'h00;
            pend_div_q <= `ODRD_DIV_RST;
            active_div_q <= `ODRD_DIV_RST;
        end else if (wr_fire && apb_req_i.paddr == `ODRD_CTRL_OFFS) begin
            state_q <= ODRD_HOLD;
            hold_q <= `ODRD_HOLD_PERIODS; // RL8
            pend_div_q <= period_of(apb_req_i.pwdata[`ODRD_CTRL_W-1:0]);
        end else begin
            case (state_q)
                ODRD_RUN: begin
                    hold_q <= 5'h00;
                end
                ODRD_HOLD: begin
                    if (period_end) begin
                        hold_q <= hold_q - 5'h01; // RL8
                        if (hold_q == 5'h01) begin
                            active_div_q <= pend_div_q; // RL8
                            state_q <= ODRD_RUN;
                        end
                    end
                end
                default: begin
                    state_q <= ODRD_RUN;
                end
            endcase
        end
    end

    // ==========================================================
    // Sample period timer

    // Counts reference clock cycles; wraps at the active divider
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= `ODRD_DIV_W'(0);
            tick_q <= 1'b0;
        end else if (period_end) begin
            cnt_q <= `ODRD_DIV_W'(0);
            tick_q <= 1'b1; // RL1 RL6
        end else begin
            cnt_q <= cnt_q + `ODRD_DIV_W'(1);
            tick_q <= 1'b0;
        end
    end

    // ==========================================================
    // Outputs

    // All outputs come from flip-flops
    always_comb begin
        apb_rsp_o.pready = pready_q;
        apb_rsp_o.pslverr = pslverr_q;
        apb_rsp_o.prdata = prdata_q;
    end
    assign sample_tick_o = tick_q;
    assign active_div_o = active_div_q;

endmodule

`default_nettype wire

/* File: test/odrd_properties.sv */
// Checker for the divider ports
`timescale 1ns/1ps
`default_nettype none
`include "odrd_regs.svh"
module odrd_chk
    import odrd_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire odrd_apb_req_t apb_req_i,
    input wire odrd_apb_rsp_t apb_rsp_o,
    input wire logic sample_tick_o,
    input wire logic [`ODRD_DIV_W-1:0] active_div_o
);
    logic [`ODRD_DIV_W-1:0] cnt_q;
    logic seen_q;
    logic rdy;
    logic rdw;
    assign rdy = apb_rsp_o.pready;
    assign rdw = rdy && !apb_req_i.pwrite;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    // Cycles since the last tick, first tick after reset skipped
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= '0;
            seen_q <= 1'b0;
        end else begin
            cnt_q <= sample_tick_o ? 17'h00001 : cnt_q + 17'h00001;
            seen_q <= seen_q | sample_tick_o;
        end
    end
    // ==========================================================
    // Bus and timer relations
    sequence s_acc;
        apb_req_i.psel && !apb_req_i.penable ##1 apb_req_i.psel && apb_req_i.penable;
    endsequence
    property p_wait; s_acc |-> !rdy ##1 rdy; endproperty
    a_wait: assert property (p_wait) else $error("no single wait");
    property p_pulse; rdy |=> !rdy; endproperty
    a_pulse: assert property (p_pulse) else $error("pready long");
    property p_bad; rdw && apb_req_i.paddr > 8'h08 |-> apb_rsp_o.pslverr && apb_rsp_o.prdata == 0;
    endproperty
    a_bad: assert property (p_bad) else $error("unmapped read");
    property p_ro; rdy && apb_req_i.pwrite && apb_req_i.paddr inside {8'h04, 8'h08}
        |-> apb_rsp_o.pslverr; endproperty
    a_ro: assert property (p_ro) else $error("ro write ok");
    property p_ctl; rdw && apb_req_i.paddr == 8'h00
        |-> !apb_rsp_o.pslverr && apb_rsp_o.prdata[31:16] == 16'h0; endproperty
    a_ctl: assert property (p_ctl) else $error("ctrl read");
    property p_chg; $changed(active_div_o) |-> sample_tick_o; endproperty
    a_chg: assert property (p_chg) else $error("divider off tick");
    property p_tick; sample_tick_o |=> !sample_tick_o; endproperty
    a_tick: assert property (p_tick) else $error("tick long");
    property p_len; sample_tick_o && seen_q |-> cnt_q == $past(active_div_o); endproperty
    a_len: assert property (p_len) else $error("period length");
    property p_rng; active_div_o >= 17'h00180 && active_div_o <= 17'h17fe0; endproperty
    a_rng: assert property (p_rng) else $error("divider range");
endmodule
bind odrd_top odrd_chk i_odrd_chk (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o), .sample_tick_o(sample_tick_o),
    .active_div_o(active_div_o));
`default_nettype wire

/* File: test/test_output_data_rate_divider.sv */
// Testbench for the output data rate divider
`timescale 1ns/1ps
`default_nettype none
`include "odrd_regs.svh"
module test_output_data_rate_divider
    import odrd_pkg::*;
;
    logic sys_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    odrd_apb_req_t req = '0;
    odrd_apb_rsp_t rsp;
    logic tick;
    logic [16:0] adiv;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    int n;
    logic [31:0] rd;
    logic er;
    logic [15:0] ctl;
    logic [10:0] bnd [4] = '{11'h7ff, 11'h600, 11'h5ff, 11'h5fe};
    odrd_top i_odrd_top (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .apb_req_i(req),
        .apb_rsp_o(rsp), .sample_tick_o(tick), .active_div_o(adiv));
    // Clock of 4 ns
    always #2 sys_clk_i = ~sys_clk_i;
    // Hang guard
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("BAD at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge sys_clk_i);
        req.penable <= 1'b1;
        do @(posedge sys_clk_i); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    // Period model
    function automatic int div(input logic [15:0] c);
        int cf [8] = '{4, 128, 64, 32, 16, 8, 2, 1};
        int ff [8] = '{1, 32, 16, 8, 4, 2, 1, 1};
        int f;
        f = (c[10:0] > 11'h5ff) ? 1535 : int'(c[10:0]);
        return cf[c[15:13]] * 384 + ff[c[15:13]] * f;
    endfunction
    // Main sequence
    initial begin
        void'($urandom(32'h5ff7));
        repeat (6) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h600);
        $display("reset test done");
        for (int i = 0; i < 16; i++) begin
            ctl = 16'($urandom);
            ctl[15:13] = 3'(i);
            ctl[12:11] = 2'b00;
            if (i inside {[1:3]}) ctl[10:0] = 11'h0;
            if (i > 7) ctl[10:0] = bnd[i % 4];
            apb(1'b1, 8'h00, {16'($urandom), ctl});
            apb(1'b0, 8'h00, 32'h0);
            chk(rd, {16'h0, ctl});
            apb(1'b0, 8'h08, 32'h0);
            chk({15'h0, rd[16:0]}, 32'(div(ctl)));
            chk(rd[31], 1'b1);
            chk(rd[21:17], 5'h10);
        end
        $display("rate table test done");
        apb(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h0);
        chk(er, 1'b1);
        apb(1'b1, 8'h04, 32'h1);
        chk(er, 1'b1);
        $display("refusal test done");
        apb(1'b1, 8'h00, 32'he000);
        n = 0;
        while (adiv === 17'h00600) begin
            @(posedge sys_clk_i);
            n += int'(tick === 1'b1);
        end
        chk(n, 16);
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (tick !== 1'b1);
        chk(n, 384);
        chk({15'h0, adiv}, 32'h180);
        $display("hold test done");
        give_verdict();
    end
endmodule
`default_nettype wire
